// ### core/autoneg_enable_bit_engine.sv
// Emulated auto-negotiation engine for the virtual PHY.
// Assumes control inputs come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module autoneg_enable_bit_engine (
  input wire logic clk,
  input wire logic rst,
  input wire logic autoneg_enable_bit,
  input wire logic an_restart,
  input wire logic manual_speed_select_low,
  input wire logic manual_duplex_select,
  input wire logic [3:0] adv_ability,
  output logic [2:0] speed_duplex,
  output logic lp_an_able,
  output logic page_set
);
  import vphy_pkg::*;

  an_state_e state_reg, state_next;
  logic [7:0] count_reg, count_next;
  logic en_prev_reg;
  logic [2:0] an_result_reg, an_result_next;
  logic [2:0] speed_reg, speed_next;
  logic lp_able_reg, lp_able_next;
  logic page_set_reg, page_set_next;
  logic [3:0] common;

  // Negotiation sequence and result resolution
  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    an_result_next = an_result_reg;
    lp_able_next = lp_able_reg;
    page_set_next = 1'b0;
    common = adv_ability & LP_ABILITY;
    case (state_reg)
      AN_IDLE: begin
        count_next = 8'h00;
      end
      AN_WAIT: begin
        if (count_reg >= AN_CYCLES - 8'h01) begin
          state_next = AN_DONE;
          page_set_next = 1'b1;
          // Partner able unless no common ability
          lp_able_next = (common != 4'h0);
          if (common[3]) begin
            an_result_next = SPD_100F;
          end else if (common[2]) begin
            an_result_next = SPD_100H;
          end else if (common[1]) begin
            an_result_next = SPD_10F;
          end else begin
            an_result_next = SPD_10H;
          end
        end else begin
          count_next = count_reg + 8'h01;
        end
      end
      AN_DONE: begin
        count_next = 8'h00;
      end
      default: begin
        state_next = AN_IDLE;
      end
    endcase
    // Restart on request or when negotiation is switched on
    if (an_restart || (autoneg_enable_bit && !en_prev_reg)) begin
      state_next = AN_WAIT;
      count_next = 8'h00;
    end
    // Indication follows result or manual settings
    if (autoneg_enable_bit) begin
      speed_next = an_result_reg;
    end else begin
      speed_next = {manual_duplex_select, manual_speed_select_low, !manual_speed_select_low};
    end
  end

  // State registers; negotiation runs right after reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= AN_WAIT;
      count_reg <= 8'h00;
      en_prev_reg <= 1'b1;
      an_result_reg <= SPD_100F;
      speed_reg <= SPD_100F;
      lp_able_reg <= LP_AN_RESET;
      page_set_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
      en_prev_reg <= autoneg_enable_bit;
      an_result_reg <= an_result_next;
      speed_reg <= speed_next;
      lp_able_reg <= lp_able_next;
      page_set_reg <= page_set_next;
    end
  end

  assign speed_duplex = speed_reg;
  assign lp_an_able = lp_able_reg;
  assign page_set = page_set_reg;

endmodule
`default_nettype wire

// ### core/autoneg_enable_bit_loopback.sv
// Virtual PHY expansion and special control/status registers,
// with far loopback of switch port 0 toward the switch engine.
// Assumes host and management strobes are on clk; strap is a pin.
`timescale 1ns/1ps
`default_nettype none
module autoneg_enable_bit_loopback (
  input wire logic clk,
  input wire logic rst,
  input wire logic [9:0] host_addr,
  input wire logic host_rd,
  input wire logic host_wr,
  input wire logic [31:0] host_wdata,
  output logic [31:0] host_rdata,
  input wire logic [4:0] mii_reg_index,
  input wire logic mii_rd,
  input wire logic mii_wr,
  input wire logic [15:0] mii_wdata,
  output logic [15:0] mii_rdata,
  input wire logic autoneg_enable_bit,
  input wire logic an_restart,
  input wire logic manual_speed_select_low,
  input wire logic manual_duplex_select,
  input wire logic [3:0] adv_ability,
  input wire logic isolate,
  input wire logic sqe_strap,
  input wire logic sw_tx_en,
  input wire logic [3:0] sw_tx_data,
  input wire logic mac_tx_en,
  input wire logic [3:0] mac_tx_data,
  output logic mac_rx_dv,
  output logic [3:0] mac_rx_data,
  output logic sw_rx_dv,
  output logic [3:0] sw_rx_data,
  output logic sw_col,
  output logic sqe_off
);
  import vphy_pkg::*;

  // ****************************************************************
  // Negotiation engine
  // ****************************************************************
  logic [2:0] speed_duplex;
  logic lp_an_able;
  logic page_set;

  autoneg_enable_bit_engine u_an (
    .clk(clk),
    .rst(rst),
    .autoneg_enable_bit(autoneg_enable_bit),
    .an_restart(an_restart),
    .manual_speed_select_low(manual_speed_select_low),
    .manual_duplex_select(manual_duplex_select),
    .adv_ability(adv_ability),
    .speed_duplex(speed_duplex),
    .lp_an_able(lp_an_able),
    .page_set(page_set)
  );

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic loop_reg, loop_next;
  logic col_test_reg, col_test_next;
  logic sqe_reg, sqe_next;
  logic page_rx_reg, page_rx_next;
  logic strap_s1_reg, strap_s2_reg;
  logic [1:0] strap_cnt_reg, strap_cnt_next;
  logic [31:0] host_rdata_reg, host_rdata_next;
  logic [15:0] mii_rdata_reg, mii_rdata_next;
  logic [31:0] exp_word, spc_word;
  logic rd_exp, host_spc_wr, mii_spc_wr;

  // Read words; reserved and fixed bits held at zero
  always_comb begin
    exp_word = 32'h0000_0000;
    exp_word[EXP_PD_FAULT_BIT] = 1'b0;
    exp_word[EXP_LP_NP_BIT] = 1'b0;
    exp_word[EXP_LOC_NP_BIT] = 1'b0;
    exp_word[EXP_PAGE_RX_BIT] = page_rx_reg;
    exp_word[EXP_LP_AN_BIT] = lp_an_able;
    spc_word = 32'h0000_0000;
    spc_word[SPC_LOOP_BIT] = loop_reg;
    spc_word[SPC_COL_TEST_BIT] = col_test_reg;
    spc_word[SPC_SPEED_LSB +: 3] = speed_duplex;
    spc_word[SPC_SQE_BIT] = sqe_reg;
  end

  // Register access decode, write and clear-on-read
  always_comb begin
    rd_exp = (host_rd && host_addr == AN_EXP_OFFSET) || (mii_rd && mii_reg_index == AN_EXP_INDEX);
    host_spc_wr = host_wr && host_addr == SPECIAL_OFFSET;
    mii_spc_wr = mii_wr && mii_reg_index == SPECIAL_INDEX;
    loop_next = loop_reg;
    col_test_next = col_test_reg;
    sqe_next = sqe_reg;
    strap_cnt_next = strap_cnt_reg;
    // Only writable bits are taken; others dropped
    if (host_spc_wr) begin
      loop_next = host_wdata[SPC_LOOP_BIT];
      col_test_next = host_wdata[SPC_COL_TEST_BIT];
      sqe_next = host_wdata[SPC_SQE_BIT];
    end else if (mii_spc_wr) begin
      loop_next = mii_wdata[SPC_LOOP_BIT];
      col_test_next = mii_wdata[SPC_COL_TEST_BIT];
      sqe_next = mii_wdata[SPC_SQE_BIT];
    end
    // Strap is taken once its synchroniser has settled
    if (strap_cnt_reg != 2'h3) begin
      strap_cnt_next = strap_cnt_reg + 2'h1;
      if (strap_cnt_reg == 2'h2) begin
        sqe_next = strap_s2_reg;
      end
    end
    // Set wins over the read clear
    if (page_set) begin
      page_rx_next = 1'b1;
    end else if (rd_exp) begin
      page_rx_next = 1'b0;
    end else begin
      page_rx_next = page_rx_reg;
    end
    host_rdata_next = host_rdata_reg;
    if (host_rd) begin
      case (host_addr)
        AN_EXP_OFFSET: host_rdata_next = exp_word;
        SPECIAL_OFFSET: host_rdata_next = spc_word;
        default: host_rdata_next = 32'h0000_0000;
      endcase
    end
    // Management sees only the low half
    mii_rdata_next = mii_rdata_reg;
    if (mii_rd) begin
      case (mii_reg_index)
        AN_EXP_INDEX: mii_rdata_next = exp_word[15:0];
        SPECIAL_INDEX: mii_rdata_next = spc_word[15:0];
        default: mii_rdata_next = 16'h0000;
      endcase
    end
  end

  // Register file flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      loop_reg <= LOOP_RESET;
      col_test_reg <= COL_TEST_RESET;
      sqe_reg <= SQE_RESET;
      page_rx_reg <= PAGE_RX_RESET;
      strap_s1_reg <= 1'b0;
      strap_s2_reg <= 1'b0;
      strap_cnt_reg <= 2'h0;
      host_rdata_reg <= 32'h0000_0000;
      mii_rdata_reg <= 16'h0000;
    end else begin
      loop_reg <= loop_next;
      col_test_reg <= col_test_next;
      sqe_reg <= sqe_next;
      page_rx_reg <= page_rx_next;
      strap_s1_reg <= sqe_strap;
      strap_s2_reg <= strap_s1_reg;
      strap_cnt_reg <= strap_cnt_next;
      host_rdata_reg <= host_rdata_next;
      mii_rdata_reg <= mii_rdata_next;
    end
  end

  // ****************************************************************
  // Port 0 data path
  // ****************************************************************
  logic mac_rx_dv_reg, mac_rx_dv_next;
  logic [3:0] mac_rx_data_reg, mac_rx_data_next;
  logic sw_rx_dv_reg, sw_rx_dv_next;
  logic [3:0] sw_rx_data_reg, sw_rx_data_next;
  logic sw_col_reg, sw_col_next;

  // Steering between MAC and loopback
  always_comb begin
    mac_rx_dv_next = 1'b0;
    mac_rx_data_next = 4'h0;
    sw_rx_dv_next = 1'b0;
    sw_rx_data_next = 4'h0;
    if (loop_reg) begin
      // Returned to the switch regardless of isolate
      sw_rx_dv_next = sw_tx_en;
      sw_rx_data_next = sw_tx_data;
    end else if (!isolate) begin
      mac_rx_dv_next = sw_tx_en;
      mac_rx_data_next = sw_tx_data;
      sw_rx_dv_next = mac_tx_en;
      sw_rx_data_next = mac_tx_data;
    end
    sw_col_next = col_test_reg && sw_tx_en;
  end

  // Data path flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mac_rx_dv_reg <= 1'b0;
      mac_rx_data_reg <= 4'h0;
      sw_rx_dv_reg <= 1'b0;
      sw_rx_data_reg <= 4'h0;
      sw_col_reg <= 1'b0;
    end else begin
      mac_rx_dv_reg <= mac_rx_dv_next;
      mac_rx_data_reg <= mac_rx_data_next;
      sw_rx_dv_reg <= sw_rx_dv_next;
      sw_rx_data_reg <= sw_rx_data_next;
      sw_col_reg <= sw_col_next;
    end
  end

  assign host_rdata = host_rdata_reg;
  assign mii_rdata = mii_rdata_reg;
  assign mac_rx_dv = mac_rx_dv_reg;
  assign mac_rx_data = mac_rx_data_reg;
  assign sw_rx_dv = sw_rx_dv_reg;
  assign sw_rx_data = sw_rx_data_reg;
  assign sw_col = sw_col_reg;
  assign sqe_off = sqe_reg;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_pad_zero: assert property (host_rd |=> host_rdata[31:16] == 16'h0000)
    else $error("upper half of host read not zero");
  a_fault_zero: assert property (host_rd && host_addr == AN_EXP_OFFSET |=> !host_rdata[4])
    else $error("parallel detection fault read as one");
  a_next_page_zero: assert property (mii_rd && mii_reg_index == AN_EXP_INDEX |=> mii_rdata[3:2] == 2'h0)
    else $error("next page ability read as one");
  a_page_clear: assert property (rd_exp && !page_set |=> !page_rx_reg)
    else $error("page received not cleared by read");
  a_page_set_wins: assert property (page_set |=> page_rx_reg ##1 (page_rx_reg || $past(rd_exp)))
    else $error("page received lost its set");
  a_lp_able_read: assert property (host_rd && host_addr == AN_EXP_OFFSET |=> host_rdata[0] == $past(lp_an_able))
    else $error("partner able bit mismatch");
  a_loop_withhold: assert property (loop_reg && sw_tx_en |=> !mac_rx_dv && sw_rx_dv)
    else $error("loopback frame reached the MAC");
  a_loop_isolate: assert property (loop_reg && isolate && sw_tx_en |=> sw_rx_data == $past(sw_tx_data))
    else $error("loopback broken under isolate");
  a_reserved_ro: assert property (host_rd && host_addr == SPECIAL_OFFSET
    |=> {host_rdata[15], host_rdata[13:8], host_rdata[6:5], host_rdata[1]} == 10'h000)
    else $error("reserved special bits read as one");
  a_speed_manual: assert property (!autoneg_enable_bit && !$past(autoneg_enable_bit)
    |-> speed_duplex == {$past(manual_duplex_select), $past(manual_speed_select_low),
    !$past(manual_speed_select_low)})
    else $error("manual speed indication mismatch");
  a_col_test: assert property (col_test_reg && sw_tx_en |=> sw_col)
    else $error("collision test not asserted");
  a_exp_write_ignored: assert property (host_wr && host_addr == AN_EXP_OFFSET && !page_set && !rd_exp
    |=> page_rx_reg == $past(page_rx_reg))
    else $error("expansion write disturbed page flag");

  c_loop_frame: cover property (loop_reg && sw_tx_en ##1 sw_rx_dv);
  c_page_read: cover property (page_rx_reg && rd_exp ##1 !page_rx_reg);
  c_col_test: cover property (col_test_reg && sw_tx_en ##1 sw_col);
  c_an_fail: cover property (page_set && !lp_an_able ##1 1'b1);

endmodule
`default_nettype wire

// ### include/vphy_pkg.sv
// Shared constants for the virtual PHY expansion and loopback block.
// Assumes a 25 MHz system clock and a 32-bit host register port.
package vphy_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  // Host byte addresses
  localparam logic [9:0] AN_EXP_OFFSET = 10'h1d8;
  localparam logic [9:0] SPECIAL_OFFSET = 10'h1dc;
  // Management register indices
  localparam logic [4:0] AN_EXP_INDEX = 5'h06;
  localparam logic [4:0] SPECIAL_INDEX = 5'h1f;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int EXP_PD_FAULT_BIT = 4;
  localparam int EXP_LP_NP_BIT = 3;
  localparam int EXP_LOC_NP_BIT = 2;
  localparam int EXP_PAGE_RX_BIT = 1;
  localparam int EXP_LP_AN_BIT = 0;
  localparam int SPC_LOOP_BIT = 14;
  localparam int SPC_COL_TEST_BIT = 7;
  localparam int SPC_SPEED_LSB = 2;
  localparam int SPC_SQE_BIT = 0;

  // ****************************************************************
  // Reset values and fixed abilities
  // ****************************************************************
  localparam logic LOOP_RESET = 1'b0;
  localparam logic COL_TEST_RESET = 1'b0;
  localparam logic PAGE_RX_RESET = 1'b0;
  localparam logic SQE_RESET = 1'b0;
  localparam logic LP_AN_RESET = 1'b1;
  // Emulated partner ability: {100F, 100H, 10F, 10H}
  localparam logic [3:0] LP_ABILITY = 4'hf;

  // Speed/duplex codes {duplex, 100M, 10M}
  localparam logic [2:0] SPD_10H = 3'h1;
  localparam logic [2:0] SPD_100H = 3'h2;
  localparam logic [2:0] SPD_10F = 3'h5;
  localparam logic [2:0] SPD_100F = 3'h6;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 40;
  localparam int AN_TIME_NS = 1000;
  localparam int AN_CYCLES_INT = (AN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] AN_CYCLES = 8'(AN_CYCLES_INT);

  typedef enum logic [1:0] {AN_IDLE, AN_WAIT, AN_DONE} an_state_e;

endpackage

// ### testbench/autoneg_enable_bit_loopback_test.sv
// Self-checking bench for the virtual PHY expansion and loopback block.
// Assumes the package, the design and the far side model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) begin compares++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("mismatch at %0t: %s", $time, msg); end end
module autoneg_enable_bit_loopback_test;
  import vphy_pkg::*;
  typedef struct {logic is_mii; logic is_spc; logic [31:0] val;} rd_note_s;
  typedef struct {logic [10:0] val; logic [10:0] mask;} dp_note_s;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [9:0] host_addr = 10'h0;
  logic host_rd = 1'b0;
  logic host_wr = 1'b0;
  logic [31:0] host_wdata = 32'h0;
  logic [31:0] host_rdata;
  logic [4:0] mii_reg_index = 5'h0;
  logic mii_rd = 1'b0;
  logic mii_wr = 1'b0;
  logic [15:0] mii_wdata = 16'h0;
  logic [15:0] mii_rdata;
  logic autoneg_enable_bit = 1'b1;
  logic an_restart = 1'b0;
  logic manual_speed_select_low = 1'b0;
  logic manual_duplex_select = 1'b0;
  logic [3:0] adv_ability = 4'hf;
  logic isolate = 1'b0;
  logic sqe_strap = 1'b1;
  logic send_sw = 1'b0;
  logic send_mac = 1'b0;
  logic [3:0] sw_nib = 4'h0;
  logic [3:0] mac_nib = 4'h0;
  logic sw_tx_en, mac_tx_en, mac_rx_dv, sw_rx_dv, sw_col, sqe_off;
  logic [3:0] sw_tx_data, mac_tx_data, mac_rx_data, sw_rx_data;
  logic [31:0] seed = 32'h2bddc164;
  logic lp_on = 1'b0;
  logic col_on = 1'b0;
  int n_mismatch = 0;
  int compares = 0;
  rd_note_s rq[$];
  dp_note_s dq[$];
  rd_note_s rn;
  dp_note_s dn;

  // ****************************************************************
  // Clock, design and far side
  // ****************************************************************
  always #20 clk = ~clk;

  autoneg_enable_bit_loopback dut_u (.clk(clk), .rst(rst), .host_addr(host_addr), .host_rd(host_rd),
    .host_wr(host_wr), .host_wdata(host_wdata), .host_rdata(host_rdata), .mii_reg_index(mii_reg_index),
    .mii_rd(mii_rd), .mii_wr(mii_wr), .mii_wdata(mii_wdata), .mii_rdata(mii_rdata),
    .autoneg_enable_bit(autoneg_enable_bit), .an_restart(an_restart),
    .manual_speed_select_low(manual_speed_select_low), .manual_duplex_select(manual_duplex_select),
    .adv_ability(adv_ability), .isolate(isolate), .sqe_strap(sqe_strap), .sw_tx_en(sw_tx_en),
    .sw_tx_data(sw_tx_data), .mac_tx_en(mac_tx_en), .mac_tx_data(mac_tx_data), .mac_rx_dv(mac_rx_dv),
    .mac_rx_data(mac_rx_data), .sw_rx_dv(sw_rx_dv), .sw_rx_data(sw_rx_data), .sw_col(sw_col),
    .sqe_off(sqe_off));

  vphy_far_side_model far_u (.clk(clk), .rst(rst), .send_sw(send_sw), .send_mac(send_mac),
    .sw_nib(sw_nib), .mac_nib(mac_nib), .sw_tx_en(sw_tx_en), .sw_tx_data(sw_tx_data),
    .mac_tx_en(mac_tx_en), .mac_tx_data(mac_tx_data));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic summarize;
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // One register access; exactly one strobe is high, reads leave a note
  task automatic acc(input logic mii, input logic wr, input logic [9:0] a, input logic [31:0] d,
                     input logic [31:0] e);
    @(negedge clk);
    host_rd = !mii && !wr;
    host_wr = !mii && wr;
    mii_rd = mii && !wr;
    mii_wr = mii && wr;
    host_addr = a;
    mii_reg_index = a[4:0];
    host_wdata = d;
    mii_wdata = d[15:0];
    if (!wr) rq.push_back('{mii, (mii ? (a[4:0] == SPECIAL_INDEX) : (a == SPECIAL_OFFSET)), e});
  endtask

  task automatic idle(input int n);
    repeat (n) begin
      @(negedge clk);
      host_rd = 1'b0;
      host_wr = 1'b0;
      mii_rd = 1'b0;
      mii_wr = 1'b0;
    end
  endtask

  // Restart negotiation with new advertisement and manual settings
  task automatic neg(input logic [3:0] adv, input logic en, input logic sel, input logic dup);
    idle(1);
    @(negedge clk);
    adv_ability = adv;
    autoneg_enable_bit = en;
    manual_speed_select_low = sel;
    manual_duplex_select = dup;
    an_restart = 1'b1;
    @(negedge clk);
    an_restart = 1'b0;
    idle(30);
  endtask

  // Random traffic both ways with random isolate; expected outputs noted
  task automatic dp(input int n);
    logic [10:0] ev;
    logic [10:0] em;
    idle(1);
    repeat (n) begin
      @(negedge clk);
      seed = lfsr(seed);
      send_sw = seed[0];
      send_mac = seed[1];
      isolate = seed[2];
      sw_nib = seed[7:4];
      mac_nib = seed[11:8];
      if (lp_on) begin
        ev = {5'h0, seed[0], seed[7:4], col_on & seed[0]};
        em = {5'h1f, 1'b1, {4{seed[0]}}, 1'b1};
      end else if (seed[2]) begin
        ev = {10'h0, col_on & seed[0]};
        em = 11'h7ff;
      end else begin
        ev = {seed[0], seed[7:4], seed[1], seed[11:8], col_on & seed[0]};
        em = {1'b1, {4{seed[0]}}, 1'b1, {4{seed[1]}}, 1'b1};
      end
      dq.push_back('{ev & em, em});
    end
    @(negedge clk);
    send_sw = 1'b0;
    send_mac = 1'b0;
    isolate = 1'b0;
  endtask

  // ****************************************************************
  // Monitor: results show just after the rising edge that samples the request
  // ****************************************************************
  always @(posedge clk) begin
    #1;
    if (rq.size() > 0) begin
      rn = rq.pop_front();
      if (rn.is_mii) `CHK(mii_rdata, rn.val[15:0], "management read")
      else `CHK(host_rdata, rn.val, "host read")
      // Control output follows the stored bit 0 of the special register
      if (rn.is_spc) `CHK(sqe_off, rn.val[0], "sqe control output")
    end
    if (dq.size() > 0) begin
      dn = dq.pop_front();
      `CHK({mac_rx_dv, mac_rx_data, sw_rx_dv, sw_rx_data, sw_col} & dn.mask, dn.val, "data path")
    end
  end

  // Hang guard
  initial begin
    repeat (6000) @(posedge clk);
    n_mismatch++;
    summarize();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    idle(3);
    acc(0, 0, SPECIAL_OFFSET, 0, 32'h19);
    acc(0, 0, AN_EXP_OFFSET, 0, 32'h1);
    idle(25);
    acc(1, 0, {5'h0, AN_EXP_INDEX}, 0, 32'h3);
    acc(0, 0, AN_EXP_OFFSET, 0, 32'h1);
    acc(0, 1, AN_EXP_OFFSET, 32'hffffffff, 0);
    acc(1, 1, {5'h0, AN_EXP_INDEX}, 32'hffff, 0);
    acc(0, 0, AN_EXP_OFFSET, 0, 32'h1);
    acc(0, 1, SPECIAL_OFFSET, 32'hffffffff, 0);
    acc(0, 0, SPECIAL_OFFSET, 0, 32'h4099);
    acc(1, 0, {5'h0, SPECIAL_INDEX}, 0, 32'h4099);
    acc(0, 0, 10'h100, 0, 0);
    acc(1, 0, 10'h002, 0, 0);
    lp_on = 1'b1;
    col_on = 1'b1;
    dp(24);
    acc(1, 1, {5'h0, SPECIAL_INDEX}, 32'hbf7c, 0);
    acc(1, 0, {5'h0, SPECIAL_INDEX}, 0, 32'h18);
    lp_on = 1'b0;
    col_on = 1'b0;
    dp(24);
    neg(4'h0, 1, 0, 0);
    acc(0, 0, AN_EXP_OFFSET, 0, 32'h2);
    acc(0, 0, SPECIAL_OFFSET, 0, 32'h4);
    neg(4'h4, 1, 0, 0);
    acc(0, 0, AN_EXP_OFFSET, 0, 32'h3);
    acc(0, 0, SPECIAL_OFFSET, 0, 32'h8);
    for (int i = 0; i < 4; i++) begin
      neg(4'hf, 0, i[0], i[1]);
      acc(0, 0, SPECIAL_OFFSET, 0, {27'h0, i[1], i[0], !i[0], 2'h0});
    end
    // Switching negotiation back on alone must rerun it
    acc(0, 0, AN_EXP_OFFSET, 0, 32'h3);
    idle(1);
    autoneg_enable_bit = 1'b1;
    idle(30);
    acc(0, 0, AN_EXP_OFFSET, 0, 32'h3);
    acc(0, 0, SPECIAL_OFFSET, 0, 32'h18);
    idle(3);
    summarize();
  end
endmodule
`default_nettype wire

// ### testbench/vphy_far_side_model.sv
// Far side model: switch port 0 transmit source and host MAC transmit source.
// Assumes the bench commands it just after the falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module vphy_far_side_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic send_sw,
  input wire logic send_mac,
  input wire logic [3:0] sw_nib,
  input wire logic [3:0] mac_nib,
  output logic sw_tx_en,
  output logic [3:0] sw_tx_data,
  output logic mac_tx_en,
  output logic [3:0] mac_tx_data
);
  // ****************************************************************
  // Line state
  // ****************************************************************
  logic [3:0] sw_last_reg;
  logic [3:0] mac_last_reg;

  // Remember what each source last put on its data lines
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sw_last_reg <= 4'h0;
      mac_last_reg <= 4'h0;
    end else begin
      sw_last_reg <= sw_tx_data;
      mac_last_reg <= mac_tx_data;
    end
  end

  // Idle lines toggle so a stale nibble can never pass for data
  assign sw_tx_en = send_sw;
  assign sw_tx_data = send_sw ? sw_nib : ~sw_last_reg;
  assign mac_tx_en = send_mac;
  assign mac_tx_data = send_mac ? mac_nib : ~mac_last_reg;
endmodule
`default_nettype wire
